// ### rtl/sbcs_pkg.sv
package sbcs_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0][7:0] LOWER_IDX = {8'hb1, 8'hae, 8'hab, 8'ha8};
  localparam logic [3:0][7:0] UPPER_IDX = {8'hb2, 8'haf, 8'hac, 8'ha9};
  localparam logic [3:0][7:0] CTL_IDX = {8'hb3, 8'hb0, 8'had, 8'haa};
  localparam logic [7:0] STATUS_IDX = 8'hb4;
  localparam logic [7:0] RDATA_IDX = 8'hb5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [7:0] UPPER0_RST = 8'hff;
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] CTL0_RST = 8'h11;
  localparam logic [7:0] CTL_RST = 8'h10;

  // ----------------------------------------------------------------
  // bus modes and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NATIVE = 2'h0;
  localparam logic [1:0] MODE_STROBE = 2'h3;
  localparam int MEM_HI = 23;
  localparam int MEM_LO = 16;
  localparam int IO_HI = 15;
  localparam int IO_LO = 8;
  localparam logic [3:0] ONE_CYCLE = 4'h1;

  typedef struct packed {
    logic [3:0] cycles;
    logic [1:0] mode;
    logic io;
    logic en;
  } sbcs_ctl_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PEN, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_WAIT,
    ST_S5, ST_S6, ST_S7, ST_NAT
  } sbcs_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
    logic data_oe_n;
    logic rw;
    logic address_strobe_n;
    logic data_strobe_n;
    logic [3:0] select_n;
  } sbcs_pins_t;

  typedef struct packed {
    sbcs_state_t state;
    logic [3:0] cnt;
    logic [1:0] last_mode;
    logic [1:0] sel;
    sbcs_ctl_t cur;
    logic write;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0][7:0] lower;
    logic [3:0][7:0] upper;
    logic [3:0][7:0] ctl;
    logic miss;
    logic waitreq;
    logic [31:0] readdata;
    sbcs_pins_t pins;
    logic req_ready;
    logic done;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
  } sbcs_st_t;

endpackage

// ### rtl/sbcs_ctrl.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// R01: read S0 drives read/write high
// R02: read S2 asserts both strobes together
// R03: peripheral drives read data in S6
// R04: entering S7 read captures data, drops strobes
// R05: peripheral releases acknowledge at S7
// R06: write S0 returns read/write high
// R07: write S1 presents valid address
// R08: write S2 asserts address strobe, read/write low
// R09: write S3 drives write data out
// R10: write S4 asserts data strobe, awaits acknowledge
// R11: late acknowledge inserts whole-state wait states
// R12: write S5 and S6 hold all signals
// R13: write S7 drops strobes, then read/write high
// R14: mode change inserts one extra cycle
// R15: no extra cycle same mode or to native
// R16: select only when enabled and in range
// R17: memory select compares lower bound, bits 23:16
// R18: memory select compares upper bound, bits 23:16
// R19: io select matches bits 15:8 to lower bound
// R20: io select ignores upper bound
// R21: lower bounds reset to zero
// R22: upper bound 0 resets ones, others zero
// R23: state length programmable 1 to 15 cycles
// R24: memory range test inclusive both ends
module sbcs_ctrl #(
  parameter int NSEL = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic [23:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic req_done,
  output logic req_miss,
  output logic [7:0] req_rdata,
  // external bus pins
  output logic [23:0] bus_addr,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n,
  input wire logic [7:0] bus_data_in,
  output logic bus_rw,
  output logic address_strobe_n,
  output logic data_strobe_n,
  input wire logic transfer_ack_n,
  output logic [3:0] select_n
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NSEL != 4) begin : g_bad_nsel
    $error("sbcs_ctrl serves exactly four selects");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam sbcs_pkg::sbcs_pins_t PINS_IDLE = '{
    addr: 24'h000000, data: 8'h00, data_oe_n: 1'b1, rw: 1'b1,
    address_strobe_n: 1'b1, data_strobe_n: 1'b1, select_n: 4'hf};

  sbcs_pkg::sbcs_st_t q;
  sbcs_pkg::sbcs_st_t d;

  logic [3:0] len;
  logic last;
  logic [3:0] hit;
  logic [1:0] hit_idx;
  logic any_hit;
  sbcs_pkg::sbcs_ctl_t hit_ctl;
  logic penalty;
  logic [31:0] rd_mux;
  logic reg_wr;

  // ----------------------------------------------------------------
  // select decode
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sbcs_pkg::sbcs_ctl_t c;
      logic [7:0] mem_byte;
      logic [7:0] io_byte;
      c = sbcs_pkg::sbcs_ctl_t'(q.ctl[i]);
      mem_byte = req_addr[sbcs_pkg::MEM_HI:sbcs_pkg::MEM_LO];
      io_byte = req_addr[sbcs_pkg::IO_HI:sbcs_pkg::IO_LO];
      if (!c.en) begin
        hit[i] = 1'b0; // R16
      end else if (c.io) begin
        hit[i] = req_io && (io_byte == q.lower[i]); // R19 R20
      end else begin
        hit[i] = !req_io && (q.lower[i] <= mem_byte) // R17 R24
          && (mem_byte <= q.upper[i]); // R18 R24
      end
    end
  end

  // lowest index wins when ranges overlap
  always_comb begin
    hit_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  assign any_hit = |hit;
  assign hit_ctl = sbcs_pkg::sbcs_ctl_t'(q.ctl[hit_idx]);
  assign penalty = (hit_ctl.mode != q.last_mode)
    && (hit_ctl.mode != sbcs_pkg::MODE_NATIVE); // R14 R15

  // ----------------------------------------------------------------
  // state length counter
  // ----------------------------------------------------------------
  // a zero length field is not valid; it runs as one cycle
  assign len = (q.cur.cycles == 4'h0) ? sbcs_pkg::ONE_CYCLE : q.cur.cycles; // R23
  assign last = (q.cnt == len - sbcs_pkg::ONE_CYCLE);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      if (avs_address == sbcs_pkg::LOWER_IDX[i]) begin
        rd_mux = {24'h000000, q.lower[i]};
      end
      if (avs_address == sbcs_pkg::UPPER_IDX[i]) begin
        rd_mux = {24'h000000, q.upper[i]};
      end
      if (avs_address == sbcs_pkg::CTL_IDX[i]) begin
        rd_mux = {24'h000000, q.ctl[i]};
      end
    end
    if (avs_address == sbcs_pkg::STATUS_IDX) begin
      rd_mux = {24'h000000, q.last_mode, q.sel, 2'h0, q.miss,
        (q.state != sbcs_pkg::ST_IDLE)};
    end
    if (avs_address == sbcs_pkg::RDATA_IDX) begin
      rd_mux = {24'h000000, q.rdata};
    end
  end

  // a write lands only on the edge where waitrequest is seen low
  assign reg_wr = avs_write && !q.waitreq && avs_byteenable[0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.ack_s1 = transfer_ack_n;
    d.ack_s2 = q.ack_s1;
    d.din_s1 = bus_data_in;
    d.din_s2 = q.din_s1;

    // bus slave: one wait cycle, then answer for one cycle
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.readdata = avs_read ? rd_mux : 32'h00000000;
    end
    if (reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_address == sbcs_pkg::LOWER_IDX[i]) begin
          d.lower[i] = avs_writedata[7:0];
        end
        if (avs_address == sbcs_pkg::UPPER_IDX[i]) begin
          d.upper[i] = avs_writedata[7:0];
        end
        if (avs_address == sbcs_pkg::CTL_IDX[i]) begin
          d.ctl[i] = avs_writedata[7:0];
        end
      end
    end

    // counter advances within a state; cleared on every state change
    if (q.state != sbcs_pkg::ST_IDLE && q.state != sbcs_pkg::ST_PEN) begin
      d.cnt = last ? 4'h0 : q.cnt + 4'h1;
    end

    unique case (q.state)
      sbcs_pkg::ST_IDLE: begin
        if (req_valid && q.req_ready) begin
          d.addr = req_addr;
          d.wdata = req_wdata;
          d.write = req_write;
          d.cnt = 4'h0;
          if (!any_hit) begin
            d.miss = 1'b1;
            d.done = 1'b1;
          end else begin
            d.miss = 1'b0;
            d.sel = hit_idx;
            d.cur = hit_ctl;
            d.req_ready = 1'b0;
            if (penalty) begin
              d.state = sbcs_pkg::ST_PEN; // R14
            end else if (hit_ctl.mode == sbcs_pkg::MODE_STROBE) begin
              d.state = sbcs_pkg::ST_S0; // R15
              d.pins.rw = 1'b1; // R01 R06
            end else begin
              d.state = sbcs_pkg::ST_NAT;
              d.pins.addr = req_addr;
              d.pins.select_n[hit_idx] = 1'b0;
              d.pins.rw = !req_write;
              if (req_write) begin
                d.pins.data = req_wdata;
                d.pins.data_oe_n = 1'b0;
              end
            end
          end
        end
      end
      sbcs_pkg::ST_PEN: begin
        // codes 01 and 10 also pay the penalty, then run as native
        if (q.cur.mode == sbcs_pkg::MODE_STROBE) begin
          d.state = sbcs_pkg::ST_S0;
          d.pins.rw = 1'b1; // R01 R06
        end else begin
          d.state = sbcs_pkg::ST_NAT; // R14
          d.pins.addr = q.addr;
          d.pins.select_n[q.sel] = 1'b0;
          d.pins.rw = !q.write;
          if (q.write) begin
            d.pins.data = q.wdata;
            d.pins.data_oe_n = 1'b0;
          end
        end
      end
      sbcs_pkg::ST_S0: begin
        if (last) begin
          d.state = sbcs_pkg::ST_S1;
          d.pins.addr = q.addr; // R07
          d.pins.select_n[q.sel] = 1'b0; // R16
        end
      end
      sbcs_pkg::ST_S1: begin
        if (last) begin
          d.state = sbcs_pkg::ST_S2;
          d.pins.address_strobe_n = 1'b0; // R02 R08
          if (q.write) begin
            d.pins.rw = 1'b0; // R08
          end else begin
            d.pins.data_strobe_n = 1'b0; // R02
          end
        end
      end
      sbcs_pkg::ST_S2: begin
        if (last) begin
          d.state = sbcs_pkg::ST_S3;
          if (q.write) begin
            d.pins.data = q.wdata; // R09
            d.pins.data_oe_n = 1'b0; // R09
          end
        end
      end
      sbcs_pkg::ST_S3: begin
        if (last) begin
          d.state = sbcs_pkg::ST_S4;
          d.pins.data_strobe_n = 1'b0; // R10
        end
      end
      sbcs_pkg::ST_S4, sbcs_pkg::ST_WAIT: begin
        // the synchronised level lags the pin, so it must settle early
        if (last) begin
          d.state = q.ack_s2 ? sbcs_pkg::ST_WAIT : sbcs_pkg::ST_S5; // R11
        end
      end
      sbcs_pkg::ST_S5: begin
        if (last) begin
          d.state = sbcs_pkg::ST_S6; // R12
        end
      end
      sbcs_pkg::ST_S6: begin
        if (last) begin
          // peripheral data is valid here after two sync stages
          d.state = sbcs_pkg::ST_S7; // R03
          d.pins.address_strobe_n = 1'b1; // R04 R13
          d.pins.data_strobe_n = 1'b1; // R04 R13
          if (!q.write) begin
            d.rdata = q.din_s2; // R04
          end
        end
      end
      sbcs_pkg::ST_S7: begin
        // acknowledge release is the peripheral's duty here
        if (last) begin
          d.state = sbcs_pkg::ST_IDLE; // R05
          d.pins = PINS_IDLE;
          d.pins.addr = q.pins.addr;
          d.pins.rw = 1'b1; // R13
          d.done = 1'b1;
          d.req_ready = 1'b1;
          d.last_mode = q.cur.mode;
        end
      end
      sbcs_pkg::ST_NAT: begin
        if (last) begin
          d.state = sbcs_pkg::ST_IDLE;
          if (!q.write) begin
            d.rdata = q.din_s2;
          end
          d.pins = PINS_IDLE;
          d.pins.addr = q.pins.addr;
          d.done = 1'b1;
          d.req_ready = 1'b1;
          d.last_mode = q.cur.mode;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam sbcs_pkg::sbcs_st_t ST_RST = '{
    state: sbcs_pkg::ST_IDLE,
    cnt: 4'h0,
    last_mode: sbcs_pkg::MODE_NATIVE,
    sel: 2'h0,
    cur: sbcs_pkg::sbcs_ctl_t'(8'h00),
    write: 1'b0,
    addr: 24'h000000,
    wdata: 8'h00,
    rdata: 8'h00,
    lower: {4{sbcs_pkg::LOWER_RST}}, // R21
    upper: {sbcs_pkg::UPPER_RST, sbcs_pkg::UPPER_RST, sbcs_pkg::UPPER_RST,
      sbcs_pkg::UPPER0_RST}, // R22
    ctl: {sbcs_pkg::CTL_RST, sbcs_pkg::CTL_RST, sbcs_pkg::CTL_RST,
      sbcs_pkg::CTL0_RST},
    miss: 1'b0,
    waitreq: 1'b1,
    readdata: 32'h00000000,
    pins: PINS_IDLE,
    req_ready: 1'b1,
    done: 1'b0,
    ack_s1: 1'b1,
    ack_s2: 1'b1,
    din_s1: 8'h00,
    din_s2: 8'h00
  };

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= ST_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = q.readdata;
  assign avs_waitrequest = q.waitreq;
  assign req_ready = q.req_ready;
  assign req_done = q.done;
  assign req_miss = q.miss;
  assign req_rdata = q.rdata;
  assign bus_addr = q.pins.addr;
  assign bus_data_out = q.pins.data;
  assign bus_data_oe_n = q.pins.data_oe_n;
  assign bus_rw = q.pins.rw;
  assign address_strobe_n = q.pins.address_strobe_n;
  assign data_strobe_n = q.pins.data_strobe_n;
  assign select_n = q.pins.select_n;

endmodule

// ### sim/sbcs_props.sv
`timescale 1ns/1ps
module sbcs_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // external bus pins
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe_n,
  input wire logic bus_rw,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic transfer_ack_n,
  input wire logic [3:0] select_n,
  // access port
  input wire logic req_ready,
  input wire logic req_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_strobe_pair: assert property ($fell(address_strobe_n) && bus_rw
    |-> $fell(data_strobe_n)) else $error("read strobes not together");
  a_write_as_rw: assert property ($fell(address_strobe_n) && !bus_rw
    |-> $fell(bus_rw) && data_strobe_n) else $error("write address phase wrong");
  a_data_first: assert property ($fell(data_strobe_n) && !bus_rw
    |-> !$past(bus_data_oe_n) && !bus_data_oe_n) else $error("data strobe before data");
  a_release_ack: assert property ($rose(address_strobe_n)
    |-> $rose(data_strobe_n) && !$past(transfer_ack_n)) else $error("bad strobe release");
  a_rw_restore: assert property ($rose(address_strobe_n) && !bus_rw
    |-> ##[1:16] bus_rw) else $error("read/write not restored");
  a_write_hold: assert property (!data_strobe_n && !bus_rw && !$past(data_strobe_n)
    |-> $stable(bus_addr) && $stable(bus_data_out)) else $error("write bus moved");
  a_select_span: assert property (!address_strobe_n
    |-> select_n != 4'hf && $stable(bus_addr)) else $error("strobe without select");
  a_read_float: assert property (bus_rw |-> bus_data_oe_n)
    else $error("data driven in read");
  a_done_idle: assert property (req_done
    |-> req_ready && address_strobe_n && select_n == 4'hf) else $error("done while busy");
endmodule
bind sbcs_ctrl sbcs_props u_sbcs_props (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
  .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n), .bus_rw(bus_rw),
  .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
  .transfer_ack_n(transfer_ack_n), .select_n(select_n), .req_ready(req_ready),
  .req_done(req_done));

// ### sim/sbcs_periph.sv
`timescale 1ns/1ps
module sbcs_periph (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus pins
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_rw,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  output logic [7:0] bus_data_in,
  output logic transfer_ack_n,
  // answer delay in cycles after address strobe
  input wire logic [3:0] ack_delay
);
  logic [7:0] mem_q [256];
  logic [3:0] cnt_q;
  logic [7:0] last_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      last_q <= 8'h00;
    end else begin
      cnt_q <= address_strobe_n ? 4'h0 : (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1);
      if (!data_strobe_n && !bus_rw) mem_q[bus_addr[7:0]] <= bus_data_out;
      last_q <= bus_data_in;
    end
  end
  // ack drops with the strobes at once, so no stale ack reaches the next cycle
  assign transfer_ack_n = address_strobe_n || (cnt_q < ack_delay);
  // outside a read the line shows a changing pattern, never the last value
  assign bus_data_in = (!address_strobe_n && bus_rw) ? mem_q[bus_addr[7:0]] : ~last_q;
endmodule

// ### sim/tb_strobe_bus_chip_select.sv
`timescale 1ns/1ps
module tb_strobe_bus_chip_select;
  typedef struct packed {
    logic [7:0] rd;
    logic chk;
    logic miss;
    logic [3:0] sel;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [31:0] t;
  } sbcs_note_t;
  localparam logic [3:0][7:0] LO_V = {8'h80, 8'h5a, 8'h40, 8'h00};
  localparam logic [3:0][7:0] UP_V = {8'hff, 8'h00, 8'h4f, 8'h3f};
  localparam logic [3:0][7:0] CT_V = {8'h10, 8'h1f, 8'h21, 8'h1d};
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, req_wdata, req_rdata, bus_data_out, bus_data_in, d0, d6;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic req_valid, req_write, req_io, req_ready, req_done, req_miss;
  logic [23:0] req_addr, bus_addr, a0;
  logic bus_data_oe_n, bus_rw, address_strobe_n, data_strobe_n, transfer_ack_n;
  logic [3:0] select_n, ack_delay;
  logic [3:0] seen = 4'h0;
  int err_count = 0, checks_done = 0, cyc = 0, seed = 99776;
  sbcs_note_t nq[$];
  sbcs_note_t nt;
  logic [7:0] aq[$];
  sbcs_ctrl u_sbcs_ctrl (.clk(clk), .rst_b(rst_b), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req_valid(req_valid), .req_write(req_write), .req_io(req_io), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_done(req_done), .req_miss(req_miss),
    .req_rdata(req_rdata), .bus_addr(bus_addr), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .bus_data_in(bus_data_in), .bus_rw(bus_rw),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .transfer_ack_n(transfer_ack_n), .select_n(select_n));
  sbcs_periph u_sbcs_periph (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_data_out(bus_data_out), .bus_rw(bus_rw), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .bus_data_in(bus_data_in),
    .transfer_ack_n(transfer_ack_n), .ack_delay(ack_delay));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic avs(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= idx;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    if (!wr) aq.push_back(d);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fail("register bus hung");
      complete_run();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // one access; lo and hi bound the cycles from take to done
  task automatic acc(input logic wr, io, input logic [23:0] a, input logic [7:0] d,
                     input logic chk, miss, input logic [3:0] sel, input logic [7:0] lo, hi);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_io <= io;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) begin
      fail("access not taken");
      complete_run();
    end
    nq.push_back('{d, chk, miss, sel, lo, hi, cyc});
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_done !== 1'b1 && n < 300);
    if (req_done !== 1'b1) begin
      fail("access hung");
      complete_run();
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_b) seen = seen | ~select_n;
    if (avs_read && avs_waitrequest === 1'b0) begin
      checks_done++;
      if (aq.size() == 0 || avs_readdata !== {24'h0, aq[0]}) fail("register value");
      if (aq.size() != 0) aq.pop_front();
    end
    if (req_done === 1'b1) begin
      if (nq.size() == 0) fail("done without request");
      else begin
        nt = nq.pop_front();
        checks_done += 2;
        if (req_miss !== nt.miss || seen !== nt.sel || (nt.chk && req_rdata !== nt.rd))
          fail("access result");
        if (cyc - nt.t < nt.lo || cyc - nt.t > nt.hi) fail("access timing");
      end
      seen = 4'h0;
    end
  end
  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {req_valid, req_write, req_io, req_addr, req_wdata, ack_delay} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      avs(1'b0, sbcs_pkg::LOWER_IDX[i], sbcs_pkg::LOWER_RST);
      avs(1'b0, sbcs_pkg::UPPER_IDX[i], i == 0 ? sbcs_pkg::UPPER0_RST : sbcs_pkg::UPPER_RST);
    end
    avs(1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      avs(1'b1, sbcs_pkg::LOWER_IDX[i], LO_V[i]);
      avs(1'b1, sbcs_pkg::UPPER_IDX[i], UP_V[i]);
      avs(1'b1, sbcs_pkg::CTL_IDX[i], CT_V[i]);
    end
    avs(1'b0, sbcs_pkg::UPPER_IDX[0], 8'h3f);
    $display("register test over");
    rnd = $random(seed);
    d0 = rnd[7:0];
    d6 = rnd[15:8];
    a0 = {8'h00, rnd[31:16]};
    acc(1'b1, 1'b0, a0, d0, 1'b0, 1'b0, 4'h1, 8'd10, 8'd10);
    acc(1'b0, 1'b0, a0, d0, 1'b1, 1'b0, 4'h1, 8'd9, 8'd9);
    avs(1'b0, sbcs_pkg::RDATA_IDX, d0);
    acc(1'b1, 1'b0, {8'h40, rnd[15:0]}, d6, 1'b0, 1'b0, 4'h2, 8'd3, 8'd3);
    // mode code 01 runs as native but still pays the change penalty
    avs(1'b1, sbcs_pkg::CTL_IDX[1], 8'h25);
    acc(1'b0, 1'b0, {8'h4f, rnd[15:0]}, d6, 1'b0, 1'b0, 4'h2, 8'd4, 8'd4);
    acc(1'b1, 1'b1, {8'h50, 8'h5a, ~rnd[23:16]}, d6, 1'b0, 1'b0, 4'h4, 8'd10, 8'd10);
    ack_delay <= 4'h6;
    acc(1'b0, 1'b1, {8'hc3, 8'h5a, ~rnd[23:16]}, d6, 1'b1, 1'b0, 4'h4, 8'd10, 8'd17);
    ack_delay <= 4'h0;
    $display("strobe test over");
    avs(1'b1, sbcs_pkg::CTL_IDX[0], 8'h2d);
    acc(1'b0, 1'b0, a0, d0, 1'b1, 1'b0, 4'h1, 8'd17, 8'd17);
    $display("state length test over");
    acc(1'b0, 1'b0, {8'h50, rnd[15:0]}, d0, 1'b0, 1'b1, 4'h0, 8'd1, 8'd1);
    acc(1'b0, 1'b0, {8'h90, rnd[15:0]}, d0, 1'b0, 1'b1, 4'h0, 8'd1, 8'd1);
    acc(1'b0, 1'b1, {8'h00, 8'h5b, rnd[7:0]}, d0, 1'b0, 1'b1, 4'h0, 8'd1, 8'd1);
    // strobe last mode, select 0 kept, miss set, idle
    avs(1'b0, sbcs_pkg::STATUS_IDX, 8'hc2);
    $display("decode test over");
    complete_run();
  end
endmodule
